/* design/mb_cfg.svh */
// Constants for the serial slave command interpreter
`ifndef MB_CFG_SVH
`define MB_CFG_SVH
// Function and sub-function codes
`define FC_RD_HOLD     8'h03
`define FC_RD_INPUT    8'h04
`define FC_WR_SINGLE   8'h06
`define FC_RD_ALARM    8'h07
`define FC_DIAG        8'h08
`define FC_SERVER_ID   8'h11
`define SUB_ECHO       16'h0000
`define SUB_RESTART    16'h0001
// Access control registers
`define ADDR_EU_PIN    16'h2064
`define ADDR_SVC_PIN   16'h2065
`define ADDR_LVL_QUERY 16'h2066
// Privilege codes, ordered so that a higher code grants more
`define LVL_SERVICE    8'h40
`define LVL_END_USER   8'h20
`define LVL_RESTRICT   8'h10
// Local register areas
`define HOLD_N         8
`define INPUT_N        8
`define CMD_INDEX      3'h7
`define EU_LAST_INDEX  3'h3
// Alarm word
`define ALARM_BITS     6
// Identification reply
`define SID_BYTE_COUNT 8'h3e
`define SID_RUNNING    8'hff
`define SID_MAKER_POS  7'h03
`define SID_PROD_POS   7'h0f
`define SID_FW_POS     7'h2f
`define SID_LAST_POS   7'h3e
// Exception codes
`define EXC_FUNC       8'h01
`define EXC_ADDR       8'h02
`define EXC_VALUE      8'h03
`define EXC_REFUSED    8'h04
`endif

/* design/mb_pkg.sv */
// Types for the serial slave command interpreter
`default_nettype none
package mb_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_INPUT, ST_SID} state_t;
endpackage : mb_pkg
`default_nettype wire

/* design/mb_slave.sv */
// Command interpreter with privilege-gated register writes
//
// What this block does
// - Code 04 reads input area; never written
// - Code 06 writes exactly one holding register
// - Code 07 answers sixteen-bit global alarm word
// - Alarm bits 0-5 flagged, 6-15 zero
// - Code 08: sub 00 echoes, 01 restarts
// - Identification reply: count 62, id, FF, names
// - Writes succeed only at sufficient privilege level
// - Starts restricted; commands allowed, setup refused
// - Correct end-user PIN grants end-user level
// - Correct service PIN grants service level
// - Level query returns 64, 32 or 16
// - PIN grants level only on exact match
// - Code 03 reads holding registers
`timescale 1ns/1ps
`default_nettype none
`include "mb_cfg.svh"
module mb_slave
    import mb_pkg::*;
#(
    parameter logic [7:0]   SERVER_ID  = 8'h5a,       // Arbitrary value
    parameter logic [95:0]  MAKER_NAME = 96'h0,       // Arbitrary value
    parameter logic [255:0] PROD_NAME  = 256'h0,      // Arbitrary value
    parameter logic [127:0] FW_VERSION = 128'h0       // Arbitrary value
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         req_valid,      // Decoded frame present
    input  wire logic [7:0]   req_func,       // Function code
    input  wire logic [15:0]  req_addr,       // Start register
    input  wire logic [7:0]   req_count,      // Registers to read
    input  wire logic [15:0]  req_value,      // Write value / diag data
    input  wire logic [15:0]  req_sub,        // Diagnostic sub-function
    input  wire logic [15:0]  eu_pin_stored,  // Stored end-user PIN
    input  wire logic [15:0]  svc_pin_stored, // Stored service PIN
    input  wire logic [5:0]   alarm_flags,    // Live alarm conditions
    input  wire logic [127:0] input_regs,     // Input area, word 0 low
    output logic              req_ready,      // Ready for a request
    output logic              resp_valid,     // Answer word valid
    output logic [15:0]       resp_word,      // Answer word or byte
    output logic              resp_last,      // Final word of answer
    output logic [7:0]        resp_exc,       // Exception code, 0 = ok
    output logic              comm_restart,   // Restart link pulse
    output logic              cmd_pulse,      // Command register hit
    output logic [127:0]      setup_regs,     // Holding area contents
    output logic [7:0]        priv_level      // Current privilege code
);

    ////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        state_t          st;       // Sequencer state
        logic            ready;    // Idle and able to take a request
        logic [7:0]      lvl;      // Privilege code
        logic [7:0][15:0] hold;    // Holding area
        logic [2:0]      idx;      // Streaming index
        logic [6:0]      pos;      // Identification byte position
        logic [7:0]      cnt;      // Words left to stream
        logic            rvalid;   // Answer valid
        logic [15:0]     rword;    // Answer data
        logic            rlast;    // Answer end
        logic [7:0]      rexc;     // Exception code
        logic            restart;  // Link restart pulse
        logic            cmd;      // Command pulse
    } slave_t;

    slave_t r_reg;   // Registered state
    slave_t r_next;  // Next state

    logic        take;         // Request accepted this cycle
    logic [8:0]  rd_end;       // End of a read span
    logic        hold_span;    // Read fits the holding area
    logic        in_span;      // Read fits the input area
    logic [7:0]  wr_ok;        // Per-entry write permission

    assign take      = req_valid && r_reg.ready;
    assign rd_end    = {1'b0, req_addr[7:0]} + {1'b0, req_count};
    assign hold_span = (req_addr[15:8] == 8'h00) && (req_count != 8'h00)
                       && (rd_end <= 9'(`HOLD_N));
    assign in_span   = (req_addr[15:8] == 8'h00) && (req_count != 8'h00)
                       && (rd_end <= 9'(`INPUT_N));

    ////////////////////////////////////////////////////////////////////
    // Protection per holding entry
    // Low entries are end-user setup, upper ones need service,
    // the last is a command entry open at every level.
    genvar gi;
    generate
        for (gi = 0; gi < `HOLD_N; gi++) begin : g_prot
            localparam logic [2:0] IDX = 3'(gi);
            assign wr_ok[gi] = (IDX == `CMD_INDEX) ? 1'b1 :
                (IDX <= `EU_LAST_INDEX) ? (r_reg.lvl >= `LVL_END_USER)
                                        : (r_reg.lvl >= `LVL_SERVICE);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Identification byte lookup, names sent high byte first
    function automatic logic [7:0] sid_byte(input logic [6:0] p);
        logic [6:0] k;
        k = 7'h00;
        if (p == 7'h00) begin
            sid_byte = `SID_BYTE_COUNT;
        end else if (p == 7'h01) begin
            sid_byte = SERVER_ID;
        end else if (p == 7'h02) begin
            sid_byte = `SID_RUNNING;
        end else if (p < `SID_PROD_POS) begin
            k = 7'(`SID_PROD_POS - 7'h01 - p);
            sid_byte = MAKER_NAME[k[3:0]*8 +: 8];
        end else if (p < `SID_FW_POS) begin
            k = 7'(`SID_FW_POS - 7'h01 - p);
            sid_byte = PROD_NAME[k[4:0]*8 +: 8];
        end else begin
            k = 7'(`SID_LAST_POS - p);
            sid_byte = FW_VERSION[k[3:0]*8 +: 8];
        end
    endfunction : sid_byte

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        r_next         = r_reg;
        r_next.rvalid  = 1'b0;
        r_next.rlast   = 1'b0;
        r_next.rexc    = 8'h00;
        r_next.restart = 1'b0;
        r_next.cmd     = 1'b0;
        case (r_reg.st)
            ST_IDLE: begin
                if (take) begin
                    // Most answers are one word, one cycle later
                    r_next.rvalid = 1'b1;
                    r_next.rlast  = 1'b1;
                    r_next.rword  = 16'h0000;
                    case (req_func)
                        `FC_RD_HOLD: begin
                            if (req_addr == `ADDR_LVL_QUERY &&
                                req_count == 8'h01) begin
                                r_next.rword = {8'h00, r_reg.lvl};
                            end else if ((req_addr == `ADDR_EU_PIN ||
                                          req_addr == `ADDR_SVC_PIN) &&
                                         req_count == 8'h01) begin
                                // PIN entries are write-only, read as 0
                                r_next.rword = 16'h0000;
                            end else if (hold_span) begin
                                r_next.rvalid = 1'b0;
                                r_next.rlast  = 1'b0;
                                r_next.idx    = req_addr[2:0];
                                r_next.cnt    = req_count;
                                r_next.st     = ST_HOLD;
                            end else begin
                                r_next.rexc = `EXC_ADDR;
                            end
                        end
                        `FC_RD_INPUT: begin
                            if (in_span) begin
                                r_next.rvalid = 1'b0;
                                r_next.rlast  = 1'b0;
                                r_next.idx    = req_addr[2:0];
                                r_next.cnt    = req_count;
                                r_next.st     = ST_INPUT;
                            end else begin
                                r_next.rexc = `EXC_ADDR;
                            end
                        end
                        `FC_WR_SINGLE: begin
                            r_next.rword = req_value;
                            if (req_addr == `ADDR_EU_PIN) begin
                                // Mismatch keeps the level
                                if (req_value == eu_pin_stored) begin
                                    r_next.lvl = `LVL_END_USER;
                                end
                            end else if (req_addr == `ADDR_SVC_PIN) begin
                                if (req_value == svc_pin_stored) begin
                                    r_next.lvl = `LVL_SERVICE;
                                end
                            end else if (req_addr[15:3] != 13'h0000) begin
                                // Query entry and unmapped: refuse
                                r_next.rexc = `EXC_ADDR;
                            end else if (wr_ok[req_addr[2:0]]) begin
                                r_next.hold[req_addr[2:0]] = req_value;
                                r_next.cmd = (req_addr[2:0] == `CMD_INDEX);
                            end else begin
                                r_next.rexc = `EXC_REFUSED;
                            end
                        end
                        `FC_RD_ALARM: begin
                            r_next.rword = {10'h000, alarm_flags};
                        end
                        `FC_DIAG: begin
                            r_next.rword = req_value;
                            if (req_sub == `SUB_ECHO) begin
                                r_next.rword = req_value;
                            end else if (req_sub == `SUB_RESTART) begin
                                // Echo goes out in the same cycle as the restart pulse
                                r_next.restart = 1'b1;
                            end else begin
                                r_next.rexc = `EXC_VALUE;
                            end
                        end
                        `FC_SERVER_ID: begin
                            r_next.rvalid = 1'b0;
                            r_next.rlast  = 1'b0;
                            r_next.pos    = 7'h00;
                            r_next.st     = ST_SID;
                        end
                        default: begin
                            r_next.rexc = `EXC_FUNC;
                        end
                    endcase
                end
            end
            ST_HOLD, ST_INPUT: begin
                // One word per cycle from the selected area
                r_next.rvalid = 1'b1;
                r_next.rword  = (r_reg.st == ST_HOLD) ?
                                r_reg.hold[r_reg.idx] :
                                input_regs[r_reg.idx*16 +: 16];
                r_next.idx    = r_reg.idx + 3'h1;
                r_next.cnt    = r_reg.cnt - 8'h01;
                if (r_reg.cnt == 8'h01) begin
                    r_next.rlast = 1'b1;
                    r_next.st    = ST_IDLE;
                end
            end
            ST_SID: begin
                // Count byte then 62 payload bytes
                r_next.rvalid = 1'b1;
                r_next.rword  = {8'h00, sid_byte(r_reg.pos)};
                r_next.pos    = r_reg.pos + 7'h01;
                if (r_reg.pos == `SID_LAST_POS) begin
                    r_next.rlast = 1'b1;
                    r_next.st    = ST_IDLE;
                end
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase
        r_next.ready = (r_next.st == ST_IDLE);
    end

    ////////////////////////////////////////////////////////////////////
    // State register; level starts restricted
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r_reg       <= '0;
            r_reg.st    <= ST_IDLE;
            r_reg.ready <= 1'b1;
            r_reg.lvl   <= `LVL_RESTRICT;
        end else begin
            r_reg <= r_next;
        end
    end

    assign req_ready    = r_reg.ready;
    assign resp_valid   = r_reg.rvalid;
    assign resp_word    = r_reg.rword;
    assign resp_last    = r_reg.rlast;
    assign resp_exc     = r_reg.rexc;
    assign comm_restart = r_reg.restart;
    assign cmd_pulse    = r_reg.cmd;
    assign setup_regs   = r_reg.hold;
    assign priv_level   = r_reg.lvl;

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_level_legal: assert property (@(posedge clock) disable iff (!rst_n)
        r_reg.lvl == `LVL_RESTRICT || r_reg.lvl == `LVL_END_USER ||
        r_reg.lvl == `LVL_SERVICE)
        else $error("privilege code outside the three levels");
    a_eu_grant: assert property (@(posedge clock) disable iff (!rst_n)
        take && req_func == `FC_WR_SINGLE && req_addr == `ADDR_EU_PIN &&
        req_value == eu_pin_stored |=> priv_level == `LVL_END_USER)
        else $error("matching end-user PIN not granted");
    a_svc_grant: assert property (@(posedge clock) disable iff (!rst_n)
        take && req_func == `FC_WR_SINGLE && req_addr == `ADDR_SVC_PIN &&
        req_value == svc_pin_stored |=> priv_level == `LVL_SERVICE)
        else $error("matching service PIN not granted");
    a_bad_pin: assert property (@(posedge clock) disable iff (!rst_n)
        take && req_func == `FC_WR_SINGLE && req_addr == `ADDR_EU_PIN &&
        req_value != eu_pin_stored |=> $stable(priv_level))
        else $error("wrong PIN changed the level");
    a_level_query: assert property (@(posedge clock) disable iff (!rst_n)
        take && req_func == `FC_RD_HOLD && req_addr == `ADDR_LVL_QUERY &&
        req_count == 8'h01 |=> resp_valid && resp_last &&
        resp_word == {8'h00, $past(priv_level)})
        else $error("level query answer wrong");
    a_refuse_setup: assert property (@(posedge clock) disable iff (!rst_n)
        take && req_func == `FC_WR_SINGLE && req_addr == 16'h0000 &&
        priv_level == `LVL_RESTRICT |=> resp_exc == `EXC_REFUSED &&
        $stable(setup_regs))
        else $error("setup write not refused at restricted level");
    a_alarm_word: assert property (@(posedge clock) disable iff (!rst_n)
        take && req_func == `FC_RD_ALARM |=>
        resp_word == {10'h000, $past(alarm_flags)} && resp_exc == 8'h00)
        else $error("alarm word wrong");
    a_diag_echo: assert property (@(posedge clock) disable iff (!rst_n)
        take && req_func == `FC_DIAG && req_sub == `SUB_ECHO |=>
        resp_word == $past(req_value) && !comm_restart)
        else $error("diagnostic echo wrong");
    a_restart: assert property (@(posedge clock) disable iff (!rst_n)
        take && req_func == `FC_DIAG && req_sub == `SUB_RESTART |=>
        comm_restart ##1 !comm_restart)
        else $error("restart pulse missing");
    a_sid_head: assert property (@(posedge clock) disable iff (!rst_n)
        take && req_func == `FC_SERVER_ID |=> !resp_valid ##1
        resp_word == 16'h003e ##2 resp_word == 16'h00ff)
        else $error("identification header wrong");

endmodule : mb_slave
`default_nettype wire

/* verif/mb_master.sv */
// Serial master model that issues decoded requests to the slave
`timescale 1ns/1ps
`default_nettype none
module mb_master (
    input  wire logic        clock,
    input  wire logic        req_ready,
    output logic             req_valid,
    output logic [7:0]       req_func,
    output logic [15:0]      req_addr,
    output logic [7:0]       req_count,
    output logic [15:0]      req_value,
    output logic [15:0]      req_sub
);
    // Idle at time zero, nothing requested
    initial begin
        req_valid = 1'b0;
        {req_func, req_addr, req_count, req_value, req_sub} = '0;
    end
    // Link settings are not modelled; no re-sync is needed after restart
    // One request: drive at falling edge, hold until taken
    task automatic send(input logic [7:0] f, input logic [15:0] a,
                        input logic [7:0] n, input logic [15:0] v,
                        input logic [15:0] s);
        @(negedge clock);
        req_valid = 1'b1;
        req_func  = f;
        req_addr  = a;
        req_count = n;
        req_value = v;
        req_sub   = s;
        // Taken at the rising edge that sees ready high
        while (req_ready !== 1'b1) @(negedge clock);
        @(negedge clock);
        // Released lines carry the inverse, never the old value
        req_valid = 1'b0;
        {req_func, req_addr, req_count, req_value, req_sub} =
            ~{f, a, n, v, s};
    endtask : send
endmodule : mb_master
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the slave command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "mb_cfg.svh"
module tb_top
    import mb_pkg::*;
;
    // Arbitrary identity strings with distinct bytes to expose order
    localparam logic [95:0]  MK = 96'h0102030405060708090a0b0c;
    localparam logic [255:0] PN = {128'h303132333435363738393a3b3c3d3e3f,
                                   128'h404142434445464748494a4b4c4d4e4f};
    localparam logic [127:0] FW = 128'h202122232425262728292a2b2c2d2e2f;
    localparam logic [7:0]   SI = 8'h3c;   // Arbitrary server identifier
    localparam logic [479:0] NM = {MK, PN, FW};
    logic clock = 1'b0, rst_n = 1'b0, req_valid, req_ready, resp_valid;
    logic resp_last, comm_restart, cmd_pulse;
    logic [7:0]   req_func, req_count, resp_exc, priv_level;
    logic [15:0]  req_addr, req_value, req_sub, resp_word, eu_pin, svc_pin;
    logic [5:0]   alarm_flags;
    logic [127:0] input_regs, setup_regs;
    logic [27:0]  q [$];              // Expected {wide,cmd,rst,exc,last,word}
    logic [15:0]  hold [8];           // Holding area model
    logic [15:0]  v;
    int mismatches = 0, compares = 0, cycles = 0, i;
    always #10 clock = ~clock;
    mb_master u_master (.clock(clock), .req_ready(req_ready),
        .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
        .req_count(req_count), .req_value(req_value), .req_sub(req_sub));
    mb_slave #(.SERVER_ID(SI), .MAKER_NAME(MK), .PROD_NAME(PN),
               .FW_VERSION(FW)) u_dut (
        .clock(clock), .rst_n(rst_n), .req_valid(req_valid),
        .req_func(req_func), .req_addr(req_addr), .req_count(req_count),
        .req_value(req_value), .req_sub(req_sub), .eu_pin_stored(eu_pin),
        .svc_pin_stored(svc_pin), .alarm_flags(alarm_flags),
        .input_regs(input_regs), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp_word(resp_word),
        .resp_last(resp_last), .resp_exc(resp_exc),
        .comm_restart(comm_restart), .cmd_pulse(cmd_pulse),
        .setup_regs(setup_regs), .priv_level(priv_level));
    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [27:0] seen, input logic [27:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Verdict and end of run
    task automatic summarize();
        if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // Note one expected answer word
    task automatic push(input logic [15:0] w, input logic l,
                        input logic [7:0] x, input logic r, input logic c,
                        input logic wd);
        q.push_back({wd, c, r, x, l, w});
    endtask : push
    // Single write, exc 0 means accepted
    task automatic wr(input logic [15:0] a, input logic [15:0] d,
                      input logic [7:0] x);
        push(d, 1'b1, x, 1'b0, (a == 16'h0007) && (x == 8'h00), 1'b1);
        u_master.send(`FC_WR_SINGLE, a, 8'h01, d, 16'h0000);
        if (x == 8'h00 && a < 16'h0008) hold[a[2:0]] = d;
    endtask : wr
    // Error answer of any request
    task automatic err(input logic [7:0] f, input logic [15:0] a,
                       input logic [7:0] n, input logic [15:0] s,
                       input logic [7:0] x);
        push(16'h0000, 1'b1, x, 1'b0, 1'b0, 1'b1);
        u_master.send(f, a, n, 16'h1234, s);
    endtask : err
    // Stream read of holding or input area
    task automatic rd(input logic [7:0] f, input int a, input int n);
        for (int j = a; j < a + n; j++)
            push(f == `FC_RD_HOLD ? hold[j] : input_regs[16*j +: 16],
                 j == a + n - 1, 8'h00, 1'b0, 1'b0, 1'b1);
        u_master.send(f, 16'(a), 8'(n), 16'h0000, 16'h0000);
    endtask : rd
    // Privilege query, 8-bit code zero-extended to a full word
    task automatic qry(input logic [7:0] lvl);
        push({8'h00, lvl}, 1'b1, 8'h00, 1'b0, 1'b0, 1'b1);
        u_master.send(`FC_RD_HOLD, `ADDR_LVL_QUERY, 8'h01, 16'h0, 16'h0);
    endtask : qry
    // Let outstanding answers arrive, bounded
    task automatic drain();
        for (int k = 0; k < 200 && q.size() > 0; k++) @(negedge clock);
        repeat (2) @(negedge clock);
    endtask : drain
    ////////////////////////////////////////////////////////////////////////
    // Answer watcher: oldest note against each answer word
    always @(negedge clock) begin : watch
        logic [27:0] e;
        logic [15:0] w;
        if (resp_valid === 1'b1) begin
            if (q.size() == 0) check(28'h1, 28'h0);
            else begin
                e = q.pop_front();
                w = resp_word;
                if (e[27] !== 1'b1) w[15:8] = e[15:8];   // Byte answers
                if (e[24:17] != 8'h00) w = e[15:0];      // Word unused
                check({e[27], cmd_pulse, comm_restart, resp_exc, resp_last,
                       w}, e);
                // Ready returns with the final word, low inside streams
                check(28'(req_ready), 28'(resp_last));
            end
        end
    end
    // Hang guard, well above the expected run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(62));
        eu_pin      = 16'($urandom);
        svc_pin     = eu_pin ^ 16'h00ff;           // Distinct PINs
        alarm_flags = 6'h3f;
        input_regs  = {$urandom, $urandom, $urandom, $urandom};
        hold        = '{default: 16'h0000};
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        check(28'(priv_level), 28'h10);
        qry(`LVL_RESTRICT);
        wr(16'h0000, 16'($urandom), `EXC_REFUSED);
        wr(16'h0007, 16'($urandom), 8'h00);
        wr(`ADDR_EU_PIN, eu_pin ^ 16'h0001, 8'h00);
        wr(`ADDR_SVC_PIN, eu_pin, 8'h00);
        qry(`LVL_RESTRICT);
        wr(`ADDR_EU_PIN, eu_pin, 8'h00);
        qry(`LVL_END_USER);
        wr(16'h0003, 16'($urandom), 8'h00);
        wr(16'h0004, 16'($urandom), `EXC_REFUSED);
        wr(`ADDR_SVC_PIN, svc_pin, 8'h00);
        qry(`LVL_SERVICE);
        for (i = 0; i < 7; i++) wr(16'(i), 16'($urandom), 8'h00);
        rd(`FC_RD_HOLD, 0, 7);
        drain();
        for (i = 0; i < 7; i++)
            check(28'(setup_regs[16*i +: 16]), 28'(hold[i]));
        rd(`FC_RD_INPUT, 0, 8);
        rd(`FC_RD_INPUT, 5, 3);
        err(`FC_RD_INPUT, 16'h0000, 8'h00, 16'h0, `EXC_ADDR);
        err(`FC_RD_HOLD, 16'h0006, 8'h03, 16'h0, `EXC_ADDR);
        wr(`ADDR_LVL_QUERY, 16'h0040, `EXC_ADDR);
        for (i = 0; i < 4; i++) begin
            drain();
            if (i > 0) alarm_flags = 6'($urandom);
            push({10'h000, alarm_flags}, 1'b1, 8'h00, 1'b0, 1'b0, 1'b1);
            u_master.send(`FC_RD_ALARM, 16'h0, 8'h0, 16'h0, 16'h0);
        end
        v = 16'($urandom);
        push(v, 1'b1, 8'h00, 1'b0, 1'b0, 1'b1);
        u_master.send(`FC_DIAG, 16'h0, 8'h0, v, `SUB_ECHO);
        push(~v, 1'b1, 8'h00, 1'b1, 1'b0, 1'b1);
        u_master.send(`FC_DIAG, 16'h0, 8'h0, ~v, `SUB_RESTART);
        err(`FC_DIAG, 16'h0, 8'h0, 16'h0002, `EXC_VALUE);
        push(16'(`SID_BYTE_COUNT), 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
        push({8'h00, SI}, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
        push(16'(`SID_RUNNING), 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
        for (i = 0; i < 60; i++)
            push({8'h00, NM[479 - 8*i -: 8]}, i == 59, 8'h00, 1'b0, 1'b0,
                 1'b0);
        u_master.send(`FC_SERVER_ID, 16'hffff, 8'hff, 16'hffff,
                      16'hffff);
        err(8'h05, 16'h0000, 8'h01, 16'h0, `EXC_FUNC);
        drain();
        // Reset in mid-run drops privilege and clears setup
        rst_n = 1'b0;
        @(negedge clock);
        check(28'(priv_level), 28'h10);
        check(28'(setup_regs[27:0]), 28'h0);
        rst_n = 1'b1;
        hold = '{default: 16'h0000};
        qry(`LVL_RESTRICT);
        wr(16'h0001, 16'h5555, `EXC_REFUSED);
        drain();
        check(28'(q.size()), 28'h0);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
